// *** cesl_defs.svh ***
`ifndef CESL_DEFS_SVH
`define CESL_DEFS_SVH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define CESL_ADDR_TOP_SRC 8'h22
`define CESL_ADDR_TOP_MASK 8'h23
`define CESL_ADDR_FLAGS 8'hB0
`define CESL_ADDR_MASK 8'hB1
`define CESL_ADDR_HEALTH 8'hB2

// ----------------------------------------
// static charge settings window
// ----------------------------------------
`define CESL_STATIC_FIRST 8'hB8
`define CESL_STATIC_LAST 8'hBE

// ----------------------------------------
// reset values and fields
// ----------------------------------------
`define CESL_RST_FLAGS 8'h00
`define CESL_RST_MASK 8'hFF
`define CESL_RST_TOP_MASK 8'hFF
`define CESL_RST_HEALTH 8'h00
`define CESL_SRC_VALID 8'hFD
`define CESL_TOP_CHG_BIT 0
`define CESL_BYTE_BITS 4'h8
`define CESL_LAST_TX_BIT 4'h7

// ----------------------------------------
// serial bus
// ----------------------------------------
`define CESL_DEF_SLAVE_ADDR 7'h5A

`endif

// *** cesl_pkg.sv ***
package cesl_pkg;
  typedef enum logic [3:0] {
    CESL_IDLE,
    CESL_ADDR,
    CESL_ADDR_ACK,
    CESL_PTR,
    CESL_PTR_ACK,
    CESL_WDATA,
    CESL_WDATA_ACK,
    CESL_RDATA,
    CESL_RDATA_ACK
  } cesl_state_t;
endpackage

// *** cesl_event_core.sv ***
`timescale 1ns/1ps
`include "cesl_defs.svh"
module cesl_event_core import cesl_pkg::*; (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // health indicators
  input wire logic [7:0] health_in,
  // register access
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // interrupt pin, active low
  output logic irq_n
);
  logic [7:0] health_q, next_health_q;
  logic [7:0] flags, next_flags;
  logic [7:0] mask, next_mask;
  logic [7:0] top_mask, next_top_mask;
  logic irq, next_irq;
  logic [7:0] changed;
  logic top_pending;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_health_q = health_in & `CESL_SRC_VALID;
    changed = (health_in ^ health_q) & `CESL_SRC_VALID;
    next_flags = flags;
    if (reg_rd && reg_addr == `CESL_ADDR_FLAGS) begin
      next_flags = `CESL_RST_FLAGS;
    end
    next_flags = next_flags | changed;
    next_mask = mask;
    next_top_mask = top_mask;
    if (reg_wr && reg_addr == `CESL_ADDR_MASK) begin
      next_mask = reg_wdata;
    end
    if (reg_wr && reg_addr == `CESL_ADDR_TOP_MASK) begin
      next_top_mask = reg_wdata;
    end
    top_pending = |flags;
    next_irq = |(flags & ~mask & `CESL_SRC_VALID)
      && !top_mask[`CESL_TOP_CHG_BIT];
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always_comb begin
    reg_rdata = 8'h00;
    unique case (reg_addr)
      `CESL_ADDR_FLAGS: reg_rdata = flags;
      `CESL_ADDR_MASK: reg_rdata = mask;
      `CESL_ADDR_HEALTH: reg_rdata = health_q;
      `CESL_ADDR_TOP_SRC: reg_rdata = {7'h00, top_pending};
      `CESL_ADDR_TOP_MASK: reg_rdata = top_mask;
      default: reg_rdata = 8'h00;
    endcase
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      health_q <= `CESL_RST_HEALTH;
      flags <= `CESL_RST_FLAGS;
      mask <= `CESL_RST_MASK;
      top_mask <= `CESL_RST_TOP_MASK;
      irq <= 1'b0;
    end else begin
      health_q <= next_health_q;
      flags <= next_flags;
      mask <= next_mask;
      top_mask <= next_top_mask;
      irq <= next_irq;
    end
  end

  assign irq_n = ~irq;
endmodule

// *** cesl_top.sv ***
`timescale 1ns/1ps
`include "cesl_defs.svh"
module cesl_top import cesl_pkg::*; #(
  parameter logic [6:0] SLAVE_ADDR = `CESL_DEF_SLAVE_ADDR
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // serial bus
  input wire logic scl,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  // health indicators
  input wire logic bypass_healthy,
  input wire logic battery_present,
  input wire logic battery_healthy,
  input wire logic charger_healthy,
  input wire logic wireless_input_valid,
  input wire logic wired_input_valid,
  input wire logic not_in_current_limit,
  // static settings protection
  input wire logic config_write_lock,
  // writes to charger settings outside this block
  output logic cfg_wr,
  output logic [7:0] cfg_addr,
  output logic [7:0] cfg_wdata,
  // interrupt pin, active low
  output logic irq_n
);
  if (SLAVE_ADDR == 7'h00) begin : g_chk
    $error("slave address zero is the general call address");
  end

  cesl_state_t state, next_state;
  logic [7:0] shreg, next_shreg;
  logic [3:0] bitcnt, next_bitcnt;
  logic [7:0] ptr, next_ptr;
  logic rw, next_rw;
  logic drive, next_drive;
  logic master_ack, next_master_ack;
  logic scl_q, sda_q;
  logic scl_rise, scl_fall, start_cond, stop_cond;
  logic reg_wr, reg_rd;
  logic [7:0] reg_rdata;
  logic [7:0] health;
  logic local_addr, static_addr;
  logic next_cfg_wr;
  logic [7:0] next_cfg_addr, next_cfg_wdata;

  // ----------------------------------------
  // bus conditions
  // ----------------------------------------
  assign scl_rise = scl && !scl_q;
  assign scl_fall = !scl && scl_q;
  assign start_cond = scl && scl_q && sda_q && !sda_i;
  assign stop_cond = scl && scl_q && !sda_q && sda_i;

  assign health = {not_in_current_limit, wired_input_valid,
    wireless_input_valid, charger_healthy, battery_healthy,
    battery_present, 1'b0, bypass_healthy};

  // ----------------------------------------
  // protocol engine
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_shreg = shreg;
    next_bitcnt = bitcnt;
    next_ptr = ptr;
    next_rw = rw;
    next_drive = drive;
    next_master_ack = master_ack;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    if (stop_cond) begin
      next_state = CESL_IDLE;
      next_drive = 1'b0;
    end else if (start_cond) begin
      next_state = CESL_ADDR;
      next_bitcnt = 4'h0;
      next_drive = 1'b0;
    end else begin
      unique case (state)
        CESL_IDLE: begin
          next_drive = 1'b0;
        end
        CESL_ADDR, CESL_PTR, CESL_WDATA: begin
          if (scl_rise && bitcnt != `CESL_BYTE_BITS) begin
            next_shreg = {shreg[6:0], sda_i};
            next_bitcnt = bitcnt + 4'h1;
          end
          if (scl_fall && bitcnt == `CESL_BYTE_BITS) begin
            next_drive = 1'b1;
            next_bitcnt = 4'h0;
            if (state == CESL_ADDR) begin
              if (shreg[7:1] == SLAVE_ADDR) begin
                next_rw = shreg[0];
                next_state = CESL_ADDR_ACK;
              end else begin
                next_drive = 1'b0;
                next_state = CESL_IDLE;
              end
            end else if (state == CESL_PTR) begin
              next_ptr = shreg;
              next_state = CESL_PTR_ACK;
            end else begin
              reg_wr = 1'b1;
              next_ptr = ptr + 8'h01;
              next_state = CESL_WDATA_ACK;
            end
          end
        end
        CESL_ADDR_ACK: begin
          if (scl_fall) begin
            if (rw) begin
              reg_rd = 1'b1;
              next_shreg = reg_rdata;
              next_drive = !reg_rdata[7];
              next_ptr = ptr + 8'h01;
              next_state = CESL_RDATA;
            end else begin
              next_drive = 1'b0;
              next_state = CESL_PTR;
            end
          end
        end
        CESL_PTR_ACK, CESL_WDATA_ACK: begin
          if (scl_fall) begin
            next_drive = 1'b0;
            next_state = CESL_WDATA;
          end
        end
        CESL_RDATA: begin
          if (scl_fall) begin
            if (bitcnt == `CESL_LAST_TX_BIT) begin
              next_drive = 1'b0;
              next_bitcnt = 4'h0;
              next_state = CESL_RDATA_ACK;
            end else begin
              next_shreg = {shreg[6:0], 1'b0};
              next_drive = !shreg[6];
              next_bitcnt = bitcnt + 4'h1;
            end
          end
        end
        CESL_RDATA_ACK: begin
          if (scl_rise) begin
            next_master_ack = !sda_i;
          end
          if (scl_fall) begin
            if (master_ack) begin
              reg_rd = 1'b1;
              next_shreg = reg_rdata;
              next_drive = !reg_rdata[7];
              next_ptr = ptr + 8'h01;
              next_state = CESL_RDATA;
            end else begin
              next_state = CESL_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // writes outside the local map
  // ----------------------------------------
  always_comb begin
    local_addr = ptr == `CESL_ADDR_FLAGS || ptr == `CESL_ADDR_MASK
      || ptr == `CESL_ADDR_HEALTH || ptr == `CESL_ADDR_TOP_SRC
      || ptr == `CESL_ADDR_TOP_MASK;
    static_addr = ptr >= `CESL_STATIC_FIRST && ptr <= `CESL_STATIC_LAST;
    next_cfg_wr = reg_wr && !local_addr
      && !(static_addr && config_write_lock);
    next_cfg_addr = cfg_addr;
    next_cfg_wdata = cfg_wdata;
    if (next_cfg_wr) begin
      next_cfg_addr = ptr;
      next_cfg_wdata = shreg;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= CESL_IDLE;
      shreg <= 8'h00;
      bitcnt <= 4'h0;
      ptr <= 8'h00;
      rw <= 1'b0;
      drive <= 1'b0;
      master_ack <= 1'b0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      cfg_wr <= 1'b0;
      cfg_addr <= 8'h00;
      cfg_wdata <= 8'h00;
    end else begin
      state <= next_state;
      shreg <= next_shreg;
      bitcnt <= next_bitcnt;
      ptr <= next_ptr;
      rw <= next_rw;
      drive <= next_drive;
      master_ack <= next_master_ack;
      scl_q <= scl;
      sda_q <= sda_i;
      cfg_wr <= next_cfg_wr;
      cfg_addr <= next_cfg_addr;
      cfg_wdata <= next_cfg_wdata;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_n = ~drive;

  // ----------------------------------------
  // event and mask registers
  // ----------------------------------------
  cesl_event_core u_core (
    .mclk(mclk),
    .rst(rst),
    .health_in(health),
    .reg_addr(ptr),
    .reg_wr(reg_wr),
    .reg_wdata(shreg),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .irq_n(irq_n)
  );
endmodule

// *** cesl_checker_assertions.sv ***
`timescale 1ns/1ps
module cesl_checker (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // serial bus
  input wire logic scl,
  input wire logic sda_oe_n,
  // health and lock
  input wire logic bypass_healthy,
  input wire logic battery_present,
  input wire logic battery_healthy,
  input wire logic charger_healthy,
  input wire logic wireless_input_valid,
  input wire logic wired_input_valid,
  input wire logic not_in_current_limit,
  input wire logic config_write_lock,
  // outputs
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  input wire logic irq_n
);
  logic [6:0] hv;
  logic [6:0] hv_q;
  logic [2:0] acks;
  logic hchg;
  assign hv = {bypass_healthy, battery_present, battery_healthy,
    charger_healthy, wireless_input_valid, wired_input_valid,
    not_in_current_limit};
  assign hchg = hv != hv_q;
  // health history and count of falls of sda_oe_n (acknowledge and read data drives), held at 7
  always_ff @(posedge mclk) begin
    hv_q <= hv;
    if (rst) begin
      acks <= 3'h0;
    end else if ($fell(sda_oe_n) && acks != 3'h7) begin
      acks <= acks + 3'h1;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  property p_reset_quiet;
    disable iff (1'h0) rst |=> irq_n && sda_oe_n && !cfg_wr;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs active after reset");
  property p_irq_unmask;
    !irq_n |-> acks >= 3'h6;
  endproperty
  a_irq_unmask: assert property (p_irq_unmask)
    else $error("irq low before both masks written");
  property p_irq_clear;
    $rose(irq_n) |-> !scl;
  endproperty
  a_irq_clear: assert property (p_irq_clear)
    else $error("irq released outside a bus access");
  property p_irq_cause;
    $fell(irq_n) |-> !scl || $past(hchg) || $past(hchg, 2)
      || $past(hchg, 3);
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("irq asserted without a cause");
  property p_cfg_pulse;
    cfg_wr |=> !cfg_wr;
  endproperty
  a_cfg_pulse: assert property (p_cfg_pulse)
    else $error("cfg_wr longer than one cycle");
  property p_cfg_lock;
    cfg_wr && cfg_addr >= 8'hB8 && cfg_addr <= 8'hBE
      |-> !$past(config_write_lock);
  endproperty
  a_cfg_lock: assert property (p_cfg_lock)
    else $error("settings write while locked");
  property p_cfg_hold;
    !cfg_wr |-> $stable(cfg_addr) && $stable(cfg_wdata);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("settings bus moved without a write");
  property p_sda_move;
    $changed(sda_oe_n) |-> !scl;
  endproperty
  a_sda_move: assert property (p_sda_move)
    else $error("data line moved while scl high");
endmodule
bind cesl_top cesl_checker u_chk (
  .mclk(mclk), .rst(rst), .scl(scl), .sda_oe_n(sda_oe_n),
  .bypass_healthy(bypass_healthy), .battery_present(battery_present),
  .battery_healthy(battery_healthy), .charger_healthy(charger_healthy),
  .wireless_input_valid(wireless_input_valid),
  .wired_input_valid(wired_input_valid),
  .not_in_current_limit(not_in_current_limit),
  .config_write_lock(config_write_lock), .cfg_wr(cfg_wr),
  .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .irq_n(irq_n)
);

// *** cesl_host_model.sv ***
`timescale 1ns/1ps
module cesl_host_model #(
  parameter logic [6:0] DEV = 7'h5A
) (
  // clock and bus line
  input wire logic mclk,
  input wire logic sda,
  output logic scl,
  output logic sda_m
);
  logic [6:0] dev = DEV;
  int nacks = 0;
  initial begin
    scl = 1'h1;
    sda_m = 1'h1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic start();
    sda_m <= 1'h1;
    tick(4);
    scl <= 1'h1;
    tick(4);
    sda_m <= 1'h0;
    tick(4);
    scl <= 1'h0;
    tick(4);
  endtask
  task automatic stop();
    sda_m <= 1'h0;
    tick(4);
    scl <= 1'h1;
    tick(4);
    sda_m <= 1'h1;
    tick(4);
  endtask
  // eight bits msb first, then the acknowledge bit
  task automatic xbyte(input logic [8:0] d, input logic chk,
    output logic [7:0] q);
    logic [8:0] r;
    for (int i = 8; i >= 0; i--) begin
      sda_m <= d[i];
      tick(4);
      scl <= 1'h1;
      tick(4);
      r[i] = sda;
      scl <= 1'h0;
      tick(1);
    end
    q = r[8:1];
    if (chk && r[0]) begin
      nacks++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    start();
    xbyte({dev, 2'h1}, 1'h1, q);
    xbyte({a, 1'h1}, 1'h1, q);
    xbyte({d, 1'h1}, 1'h1, q);
    stop();
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    start();
    xbyte({dev, 2'h1}, 1'h1, q);
    xbyte({a, 1'h1}, 1'h1, q);
    start();
    xbyte({dev, 2'h3}, 1'h1, q);
    xbyte(9'h1FF, 1'h0, q);
    stop();
  endtask
  // two bytes from one pointer, first byte acknowledged by the host
  task automatic rd2(input logic [7:0] a, output logic [7:0] q0,
    output logic [7:0] q1);
    start();
    xbyte({dev, 2'h1}, 1'h1, q0);
    xbyte({a, 1'h1}, 1'h1, q0);
    start();
    xbyte({dev, 2'h3}, 1'h1, q0);
    xbyte(9'h1FE, 1'h0, q0);
    xbyte(9'h1FF, 1'h0, q1);
    stop();
  endtask
endmodule

// *** testbench.sv ***
`timescale 1ns/1ps
module testbench;
  localparam logic [6:0] DEV = 7'h5A;
  logic mclk = 1'h0;
  logic rst = 1'h1;
  logic lock = 1'h0;
  logic [7:0] hv = 8'h00;
  logic [7:0] q;
  logic [7:0] cfg_addr;
  logic [7:0] cfg_wdata;
  logic scl, sda_m, sda_o, sda_oe_n, cfg_wr, irq_n;
  wire sda = sda_m & (sda_oe_n | sda_o);
  int mismatches = 0;
  int n_checks = 0;
  int n_cfg = 0;
  always #25 mclk = ~mclk;
  always @(negedge mclk) if (cfg_wr === 1'h1) n_cfg++;
  cesl_top #(.SLAVE_ADDR(DEV)) DUT (
    .mclk(mclk), .rst(rst), .scl(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .bypass_healthy(hv[0]), .battery_present(hv[2]),
    .battery_healthy(hv[3]), .charger_healthy(hv[4]),
    .wireless_input_valid(hv[5]), .wired_input_valid(hv[6]),
    .not_in_current_limit(hv[7]), .config_write_lock(lock),
    .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .irq_n(irq_n)
  );
  cesl_host_model #(.DEV(DEV)) host (
    .mclk(mclk), .sda(sda), .scl(scl), .sda_m(sda_m)
  );
  task automatic chk(input string s, input logic [7:0] v, input logic [7:0] e);
    n_checks++;
    if (v !== e) begin
      mismatches++;
      $display("BAD %s exp %h seen %h", s, e, v);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, q);
    chk($sformatf("reg %h", a), q, e);
  endtask
  task automatic wirq(input logic e);
    repeat (4) @(negedge mclk);
    for (int i = 0; i < 8 && irq_n !== e; i++) @(negedge mclk);
    chk("irq_n", {7'h00, irq_n}, {7'h00, e});
  endtask
  task automatic t_reset();
    rst <= 1'h1;
    repeat (16) @(posedge mclk);
    rst <= 1'h0;
    @(posedge mclk);
    rdchk(8'hB1, 8'hFF);
    rdchk(8'h23, 8'hFF);
    rdchk(8'hB0, 8'h00);
    rdchk(8'h22, 8'h00);
  endtask
  task automatic t_events();
    logic [7:0] h = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (i != 1) begin
        h = h ^ (8'h01 << i);
        hv <= h;
        rdchk(8'h22, 8'h01);
        rdchk(8'hB2, h);
        rdchk(8'hB0, 8'h01 << i);
        rdchk(8'hB0, 8'h00);
        rdchk(8'h22, 8'h00);
      end
    end
    hv <= 8'h00;
    rdchk(8'hB0, 8'hFD);
  endtask
  task automatic t_mask();
    host.wr(8'hB1, 8'hFB);
    host.wr(8'h23, 8'hFE);
    rdchk(8'hB1, 8'hFB);
    hv <= 8'h08;
    wirq(1'h1);
    rdchk(8'hB0, 8'h08);
    hv <= 8'h0C;
    wirq(1'h0);
    host.wr(8'h23, 8'hFF);
    wirq(1'h1);
    host.wr(8'h23, 8'hFE);
    wirq(1'h0);
    rdchk(8'hB0, 8'h04);
    wirq(1'h1);
  endtask
  task automatic t_lock();
    lock <= 1'h1;
    host.wr(8'hB8, 8'h3C);
    chk("cfg_count", n_cfg[7:0], 8'h00);
    host.wr(8'hB0, 8'hFF);
    rdchk(8'hB0, 8'h00);
    host.wr(8'hC0, 8'h11);
    chk("cfg_count", n_cfg[7:0], 8'h01);
    chk("cfg_addr", cfg_addr, 8'hC0);
    lock <= 1'h0;
    host.wr(8'hBE, 8'h5C);
    chk("cfg_count", n_cfg[7:0], 8'h02);
    chk("cfg_addr", cfg_addr, 8'hBE);
    chk("cfg_wdata", cfg_wdata, 8'h5C);
    host.dev = 7'h2B;
    host.wr(8'hB1, 8'h00);
    host.dev = DEV;
    chk("nacks", host.nacks[7:0], 8'h03);
    rdchk(8'hB1, 8'hFB);
  endtask
  // burst read, then a toggle landing in the clearing cycle of a read
  task automatic t_burst();
    logic [7:0] q1;
    host.rd2(8'hB1, q, q1);
    chk("burst0", q, 8'hFB);
    chk("burst1", q1, 8'h0C);
    fork
      host.rd(8'hB0, q);
      begin
        repeat (274) @(posedge mclk);
        hv <= 8'h08;
      end
    join
    chk("clr_read", q, 8'h00);
    rdchk(8'hB0, 8'h04);
    wirq(1'h1);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    t_reset();
    t_events();
    t_mask();
    t_lock();
    t_burst();
    hv <= 8'h00;
    t_reset();
    end_of_test();
  end
endmodule
